// file: asr_pkg.sv
// Shared constants, types and helpers for both ends of the angle sensor serial link.
// Assumes a 20 MHz reference clock on each end; all times are converted from it.
package asr_pkg;

  // ==========================================================================
  // Word layout
  // ==========================================================================
  localparam int          WORD_W          = 16;      // Bits in one framed transfer.
  localparam int          DATA_W          = 14;      // Sensor word bits.
  localparam int          ANGLE_W         = 13;      // Angle field bits.
  localparam int          BYTE_DATA_W     = 7;       // Data bits per transferred byte.
  localparam int          STATUS_POS      = 13;      // Position of status_flag_bit.
  localparam int          ERR_W           = 2;       // Width of the error code.
  localparam logic [1:0]  ERR_RESET       = 2'h0;    // No valid value since reset.
  localparam logic [1:0]  ERR_MAGNET_LOST = 2'h1;    // Magnet lost.
  localparam logic [15:0] RESET_WORD      = 16'h8001; // Status set, code 00, parities odd.

  // ==========================================================================
  // Trim commands, first bit sent in the top position
  // ==========================================================================
  localparam int          CMD_W         = 5;
  localparam logic [4:0]  CMD_TRIM_CH1  = 5'h02;
  localparam logic [4:0]  CMD_TRIM_CH2  = 5'h04;
  localparam logic [4:0]  CMD_TRIM_EXIT = 5'h00;
  localparam logic [1:0]  TRIM_NONE     = 2'h0;
  localparam logic [1:0]  TRIM_CH1      = 2'h1;
  localparam logic [1:0]  TRIM_CH2      = 2'h2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS  = 50;
  localparam int UPDATE_TIME_NS = 260000;   // New angle result interval.
  localparam int UPDATE_CYC     = UPDATE_TIME_NS / CLK_PERIOD_NS;
  localparam int LEAD_TIME_NS   = 1200;     // Chip select low to first falling clock.
  localparam int LEAD_CYC       = (LEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_NS    = 500;      // Half of the 1 us least serial clock cycle.
  localparam int SCK_HALF_CYC   = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LAG_TIME_NS    = 15;       // Last clock edge to chip select high.
  localparam int LAG_CYC        = (LAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIM_HALF_NS   = 500;      // Half period of the 1 MHz trim clock.
  localparam int TRIM_HALF_CYC  = (TRIM_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIM_DATA_CYC  = TRIM_HALF_CYC / 2;

  // ==========================================================================
  // State types
  // ==========================================================================
  typedef enum logic [1:0] {
    TR_IDLE = 2'b00,
    TR_BITS = 2'b01,
    TR_STOP = 2'b10,
    TR_END  = 2'b11
  } asr_trim_state_t;

  typedef enum logic [3:0] {
    H_IDLE   = 4'b0000,
    H_LEAD   = 4'b0001,
    H_LOW    = 4'b0010,
    H_HIGH   = 4'b0011,
    H_LAG    = 4'b0100,
    H_TSTART = 4'b0101,
    H_TLOW   = 4'b0110,
    H_THIGH  = 4'b0111,
    H_TSTOP  = 4'b1000,
    H_TEND   = 4'b1001
  } asr_host_state_t;

  // Odd parity: the bit makes the count of ones in data plus parity odd.
  function automatic logic asr_odd_par(input logic [6:0] d);
    return ~(^d);
  endfunction : asr_odd_par

  // Upper byte first, each byte seven data bits then its parity bit.
  function automatic logic [15:0] asr_pack(input logic [13:0] d);
    return {d[13:7], asr_odd_par(d[13:7]), d[6:0], asr_odd_par(d[6:0])};
  endfunction : asr_pack

endpackage : asr_pkg

// file: asr_link_if.sv
// Pins between the sensor device end and its master / trim programmer end.
// Assumes the testbench instantiates it once and connects both ends.
`timescale 1ns/1ps
interface asr_link_if;
  logic sck;       // Serial clock, idles high, made by the master.
  logic cs_n;      // Chip select, active low, made by the master.
  logic miso;      // Serial data from the device.
  logic trim_clk;  // Trim clock, idles high, made by the programmer.
  logic trim_sel;  // trim_select_line, idles high, made by the programmer.

  modport dev  (input sck, input cs_n, input trim_clk, input trim_sel, output miso);
  modport host (output sck, output cs_n, output trim_clk, output trim_sel, input miso);
endinterface : asr_link_if

// file: asr_dev.sv
// Device end: formats angle results into 16-bit words, shifts them out as an SPI
// slave, decodes trim commands and drives the test square wave.
// Assumes angle, channel-below-threshold flags and sample strobe come from logic
// on ref_clk_i; the serial clock and trim pins arrive from the far end.
//
// How it works
// RL1: Slave only, clock idles high, phase one.
// RL2: Next data bit driven after each falling clock.
// RL3: Master samples bits on rising clock.
// RL4: Chip select fall reloads shift register fully.
// RL5: Clock may pause; position held while selected.
// RL6: Each frame carries sixteen bits from latest angle.
// RL7: Master waits 1.2 us before first fall.
// RL8: Upper byte bits 13..7 first, lower second.
// RL9: Seven data bits MSB first, parity last.
// RL10: Odd parity per byte; master checks it.
// RL11: Low thirteen bits unsigned angle, 180/8192 steps.
// RL12: Top bit zero normally, one on error.
// RL13: On error, low two bits carry code.
// RL14: Code 00 after reset, 01 magnet lost.
// RL15: Magnet lost when both channels below threshold.
// RL16: Command starts: select falls while clock high.
// RL17: Five command bits sampled on rising clock.
// RL18: Fifth high: select rises, clock falls, done.
// RL19: 00010 channel 1, 00100 channel 2, 00000 exit.
// RL20: Only complete commands or reset leave trim.
// RL21: Trim active, changing input: square wave out.
// RL22: External high reset overrides, any time.
// RL23: Supply monitor releases or forces reset.
// RL24: New result every 0.26 ms interval.
`timescale 1ns/1ps
module asr_dev
  import asr_pkg::*;
#(
  parameter int UPDATE_CYC_P = UPDATE_CYC  // Cycles between published results.
) (
  // Clock and resets.
  input  wire logic               ref_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               ext_rst_i,
  input  wire logic               supply_ok_i,
  // Results from the angle computation.
  input  wire logic [ANGLE_W-1:0] angle_i,
  input  wire logic               ch1_below_i,
  input  wire logic               ch2_below_i,
  input  wire logic               sample_ready_i,
  // Link pins.
  asr_link_if.dev                 link,
  // Status outputs.
  output logic                    tout_o,
  output logic [1:0]              trim_mode_o
);

  localparam int UW = $clog2(UPDATE_CYC_P + 1);

  // ==========================================================================
  // Reset generation
  // ==========================================================================
  logic       rst_async_n;  // Any reset source asserted pulls this low.
  logic [1:0] rst_sync;     // Release synchroniser.
  logic       rst_n;        // Core reset, released on the clock.

  // The external pin and the supply monitor act without a clock; release is clocked.
  assign rst_async_n = nrst_i & supply_ok_i & ~ext_rst_i; // RL22 RL23

  // Release is delayed two edges so no flop leaves reset on a partial edge.
  always_ff @(posedge ref_clk_i or negedge rst_async_n) begin
    if (!rst_async_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================================
  // Pin synchronisers: bit 0 chip select, bit 1 trim clock, bit 2 trim select
  // ==========================================================================
  logic [2:0] pin_meta;  // First stage, read only by the second.
  logic [2:0] pin_sync;  // Stable copies.
  logic [2:1] pin_prev;  // Previous trim levels for edge detection.

  // All three pins idle high, so that is their reset value.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 3'h7;
      pin_sync <= 3'h7;
      pin_prev <= 2'h3;
    end else begin
      pin_meta <= {link.trim_sel, link.trim_clk, link.cs_n};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync[2:1];
    end
  end

  // ==========================================================================
  // Sample capture and word build
  // ==========================================================================
  logic [ANGLE_W-1:0] last_angle;  // Latest angle from the computation.
  logic               lost;        // Magnet lost at latest sample.
  logic               have_value;  // At least one sample since reset.
  logic               moving;      // High for one cycle after a sample that differed from the previous one.
  logic [DATA_W-1:0]  next_data;   // Sensor word to be published.

  // Capture each result as it arrives.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      last_angle <= '0;
      lost       <= 1'b0;
      have_value <= 1'b0;
      moving     <= 1'b0;
    end else if (sample_ready_i) begin
      last_angle <= angle_i;
      lost       <= ch1_below_i & ch2_below_i; // RL15
      have_value <= 1'b1;
      moving     <= (angle_i != last_angle);
    end else begin
      moving     <= 1'b0;
    end
  end

  // Error words keep only the top eleven angle bits beside the code.
  always_comb begin
    if (!have_value) begin
      next_data = {1'b1, last_angle[ANGLE_W-1:ERR_W], ERR_RESET}; // RL12 RL13 RL14
    end else if (lost) begin
      next_data = {1'b1, last_angle[ANGLE_W-1:ERR_W], ERR_MAGNET_LOST}; // RL13 RL14
    end else begin
      next_data = {1'b0, last_angle}; // RL11 RL12
    end
  end

  // ==========================================================================
  // Publish timer and frozen transmit word
  // ==========================================================================
  logic [UW-1:0]     upd_cnt;  // Counts reference cycles to the next result.
  logic              pending;  // A result is due but a frame is running.
  logic [WORD_W-1:0] tx_word;  // Word read by the serial-clock domain.

  // Results are published at a fixed interval of the local clock.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      upd_cnt <= '0;
    end else if (upd_cnt == UW'(UPDATE_CYC_P - 1)) begin
      upd_cnt <= '0; // RL24
    end else begin
      upd_cnt <= upd_cnt + UW'(1);
    end
  end

  // The word changes only while chip select is high. The master's lead time
  // is far longer than the two-flop delay, so the serial domain always sees a
  // settled word at its first edge; this stands in for a handshake.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_word <= RESET_WORD;
      pending <= 1'b0;
    end else if ((upd_cnt == UW'(UPDATE_CYC_P - 1)) || pending) begin
      if (pin_sync[0]) begin
        tx_word <= asr_pack(next_data); // RL6 RL8 RL10
        pending <= 1'b0;
      end else begin
        pending <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Serial shifter on the link clock
  // ==========================================================================
  logic       frame_rst_n;  // Low outside a frame and during reset.
  logic [4:0] bit_cnt;      // Bits already driven in this frame.

  // Chip select high restarts the frame, so every fall begins a new word.
  assign frame_rst_n = rst_async_n & ~link.cs_n; // RL4

  // Bits change on falling clock, the master samples the rising one.
  // A paused clock simply leaves count and data where they are.
  always_ff @(negedge link.sck or negedge frame_rst_n) begin // RL1 RL5
    if (!frame_rst_n) begin
      bit_cnt   <= 5'h00;
      link.miso <= 1'b0;
    end else if (bit_cnt != 5'(WORD_W)) begin
      link.miso <= tx_word[4'(WORD_W - 1) - bit_cnt[3:0]]; // RL2 RL9
      bit_cnt   <= bit_cnt + 5'h01;
    end else begin
      link.miso <= 1'b0;
    end
  end

  // ==========================================================================
  // Trim command decoder
  // ==========================================================================
  asr_trim_state_t   tr_state;  // Protocol position.
  logic [CMD_W-1:0]  cmd;       // Shifted command, first bit on top.
  logic [2:0]        cmd_cnt;   // Command bits taken.
  logic              clk_rise;
  logic              clk_fall;
  logic              sel_rise;
  logic              sel_fall;

  assign clk_rise = pin_sync[1] & ~pin_prev[1];
  assign clk_fall = ~pin_sync[1] & pin_prev[1];
  assign sel_rise = pin_sync[2] & ~pin_prev[2];
  assign sel_fall = ~pin_sync[2] & pin_prev[2];

  // A start condition restarts decoding from any state.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tr_state    <= TR_IDLE;
      cmd         <= '0;
      cmd_cnt     <= 3'h0;
      trim_mode_o <= TRIM_NONE;
    end else if (sel_fall && pin_sync[1]) begin
      tr_state <= TR_BITS; // RL16
      cmd_cnt  <= 3'h0;
    end else begin
      case (tr_state)
        TR_BITS: begin
          if (clk_rise) begin
            cmd     <= {cmd[CMD_W-2:0], pin_sync[2]}; // RL17
            cmd_cnt <= cmd_cnt + 3'h1;
            if (cmd_cnt == 3'(CMD_W - 1)) begin
              tr_state <= TR_STOP;
            end
          end
        end
        TR_STOP: begin
          // Select must rise while the clock is still high.
          if (sel_rise && pin_sync[1]) begin
            tr_state <= TR_END; // RL18
          end else if (clk_fall) begin
            tr_state <= TR_IDLE; // RL20
          end
        end
        TR_END: begin
          // Only the final falling clock makes the command take effect.
          if (clk_fall) begin
            tr_state <= TR_IDLE;
            case (cmd)
              CMD_TRIM_CH1:  trim_mode_o <= TRIM_CH1; // RL19
              CMD_TRIM_CH2:  trim_mode_o <= TRIM_CH2;
              CMD_TRIM_EXIT: trim_mode_o <= TRIM_NONE; // RL20
              default:       trim_mode_o <= trim_mode_o;
            endcase
          end
        end
        default: begin
          tr_state <= TR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Test output
  // ==========================================================================
  // Toggles on each changed sample in trim mode; a static input gives no wave.
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tout_o <= 1'b0;
    end else if (trim_mode_o == TRIM_NONE) begin
      tout_o <= 1'b0;
    end else if (moving) begin
      tout_o <= ~tout_o; // RL21
    end
  end

endmodule : asr_dev

// file: asr_host.sv
// Master end: reads framed sensor words over the serial link and sends trim
// commands. Both link clocks are made here by dividing ref_clk_i.
// Assumes a device end on the same interface and one request at a time.
`timescale 1ns/1ps
module asr_host
  import asr_pkg::*;
(
  // Clock and reset.
  input  wire logic               ref_clk_i,
  input  wire logic               nrst_i,
  // Requests.
  input  wire logic               read_req_i,
  input  wire logic               trim_req_i,
  input  wire logic [CMD_W-1:0]   trim_cmd_i,
  output logic                    busy_o,
  // Read results.
  output logic                    rx_valid_o,
  output logic [WORD_W-1:0]       rx_word_o,
  output logic [ANGLE_W-1:0]      angle_o,
  output logic                    status_o,
  output logic [ERR_W-1:0]        err_code_o,
  output logic                    parity_err_o,
  // Link pins.
  asr_link_if.host                link
);

  // ==========================================================================
  // Data synchroniser
  // ==========================================================================
  logic miso_meta;  // First stage, read only by the second.
  logic miso_sync;  // Settled data.

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      miso_meta <= 1'b0;
      miso_sync <= 1'b0;
    end else begin
      miso_meta <= link.miso;
      miso_sync <= miso_meta;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  asr_host_state_t   state;
  logic [4:0]        tmr;     // Cycles left in the current phase.
  logic [3:0]        bit_idx; // Bit within frame or command.
  logic [WORD_W-1:0] rx_sh;   // Received bits, first at the top.
  logic [CMD_W-1:0]  cmd_sh;  // Command bits still to send.
  logic [DATA_W-1:0] rx_data; // Data bits with parity removed.

  assign busy_o  = (state != H_IDLE);
  assign rx_data = {rx_sh[15:9], rx_sh[7:1]};

  // One process for all pins keeps phase changes in strict order; data on the
  // trim select line moves mid-low so it never moves with a clock edge.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state         <= H_IDLE;
      tmr           <= 5'h00;
      bit_idx       <= 4'h0;
      rx_sh         <= '0;
      cmd_sh        <= '0;
      link.sck      <= 1'b1;
      link.cs_n     <= 1'b1;
      link.trim_clk <= 1'b1;
      link.trim_sel <= 1'b1;
      rx_valid_o    <= 1'b0;
      rx_word_o     <= '0;
      angle_o       <= '0;
      status_o      <= 1'b0;
      err_code_o    <= '0;
      parity_err_o  <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (tmr != 5'h00) begin
        tmr <= tmr - 5'h01;
      end
      case (state)
        H_IDLE: begin
          if (read_req_i) begin
            link.cs_n <= 1'b0;
            tmr       <= 5'(LEAD_CYC - 1); // RL7
            state     <= H_LEAD;
          end else if (trim_req_i) begin
            link.trim_sel <= 1'b0; // RL16
            cmd_sh        <= trim_cmd_i;
            tmr           <= 5'(TRIM_HALF_CYC - 1);
            state         <= H_TSTART;
          end
        end
        H_LEAD: begin
          if (tmr == 5'h00) begin
            link.sck <= 1'b0; // RL1
            bit_idx  <= 4'h0;
            tmr      <= 5'(SCK_HALF_CYC - 1);
            state    <= H_LOW;
          end
        end
        H_LOW: begin
          if (tmr == 5'h00) begin
            link.sck <= 1'b1;
            rx_sh    <= {rx_sh[WORD_W-2:0], miso_sync}; // RL3
            tmr      <= 5'(SCK_HALF_CYC - 1);
            state    <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr == 5'h00) begin
            if (bit_idx == 4'(WORD_W - 1)) begin
              tmr   <= 5'(LAG_CYC - 1);
              state <= H_LAG;
            end else begin
              link.sck <= 1'b0;
              bit_idx  <= bit_idx + 4'h1;
              tmr      <= 5'(SCK_HALF_CYC - 1);
              state    <= H_LOW;
            end
          end
        end
        H_LAG: begin
          if (tmr == 5'h00) begin
            link.cs_n    <= 1'b1;
            rx_valid_o   <= 1'b1;
            rx_word_o    <= rx_sh;
            angle_o      <= rx_data[ANGLE_W-1:0];
            status_o     <= rx_data[STATUS_POS];
            err_code_o   <= rx_data[ERR_W-1:0];
            parity_err_o <= ~(^rx_sh[15:8]) | ~(^rx_sh[7:0]); // RL10
            state        <= H_IDLE;
          end
        end
        H_TSTART: begin
          if (tmr == 5'h00) begin
            link.trim_clk <= 1'b0;
            bit_idx       <= 4'h0;
            tmr           <= 5'(TRIM_HALF_CYC - 1);
            state         <= H_TLOW;
          end
        end
        H_TLOW: begin
          if (tmr == 5'(TRIM_DATA_CYC)) begin
            link.trim_sel <= cmd_sh[CMD_W-1]; // RL17
            cmd_sh        <= {cmd_sh[CMD_W-2:0], 1'b0};
          end
          if (tmr == 5'h00) begin
            link.trim_clk <= 1'b1;
            tmr           <= 5'(TRIM_HALF_CYC - 1);
            state         <= H_THIGH;
          end
        end
        H_THIGH: begin
          if (bit_idx == 4'(CMD_W - 1) && tmr == 5'(TRIM_DATA_CYC)) begin
            link.trim_sel <= 1'b1; // RL18
            state         <= H_TSTOP;
          end else if (tmr == 5'h00) begin
            link.trim_clk <= 1'b0;
            bit_idx       <= bit_idx + 4'h1;
            tmr           <= 5'(TRIM_HALF_CYC - 1);
            state         <= H_TLOW;
          end
        end
        H_TSTOP: begin
          if (tmr == 5'h00) begin
            link.trim_clk <= 1'b0; // RL18
            tmr           <= 5'(TRIM_HALF_CYC - 1);
            state         <= H_TEND;
          end
        end
        H_TEND: begin
          if (tmr == 5'h00) begin
            link.trim_clk <= 1'b1;
            state         <= H_IDLE;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

endmodule : asr_host

// file: asr_link_props.sv
// Wire checks on the link between the host end and the device end.
// Assumes the bench hands in the reference clock and the host reset.
`timescale 1ns/1ps
module asr_link_props (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic miso,
  input wire logic trim_clk,
  input wire logic trim_sel
);
  // ==========
  // Link rules
  // ==========
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  chk_sck_idle_high: assert property (cs_n |-> sck)
    else $error("serial clock low outside a frame");
  chk_sck_in_frame: assert property ($fell(sck) |-> !cs_n)
    else $error("serial clock fell without select");
  chk_lead_wait: assert property ($fell(cs_n) |-> sck [*8] ##1 sck [*8] ##1 sck [*8])
    else $error("first clock fall came too soon");
  chk_sck_low_half: assert property ($fell(sck) |-> !sck [*8])
    else $error("serial clock low phase too short");
  // The reload at select fall may land late, so only settled frames count.
  chk_miso_held: assert property (!cs_n && !$past(cs_n, 4) && sck && $past(sck)
    |-> $stable(miso))
    else $error("data moved while clock stayed high");
  // Data bits may fall mid-low; any other fall must be a start with the clock high.
  chk_trim_start: assert property ($fell(trim_sel) |-> trim_clk || !$past(trim_clk, 4))
    else $error("trim start with clock low");
  chk_trim_no_frame: assert property (!trim_sel |-> cs_n)
    else $error("frame during trim command");
  chk_trim_clk_low: assert property ($fell(trim_clk) |-> !trim_clk [*8])
    else $error("trim clock low phase too short");
  cover property ($rose(cs_n));
  cover property ($rose(trim_sel) && trim_clk);
  cover property ($fell(sck) && miso);
endmodule : asr_link_props

// file: tb_angle_sensor_serial_output.sv
// Bench joining both ends, checked against a behavioural model.
// Assumes the package, interface, both ends and the checker compile first.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb_angle_sensor_serial_output;
  import asr_pkg::*;
  localparam int UPD = 50;  // Short publish interval keeps the run brief.
  logic clk, nrst, ext_rst, sup_ok, smp, c1b, c2b, rd, tr, busy, rxv, perr, tout, m_tout;
  logic [12:0] ang, last_ang;
  logic [4:0]  cmd;
  logic [15:0] rxw, exp_w;
  logic [1:0]  tm, m_tm, h_ec;
  logic [12:0] h_ang;
  logic        h_st;
  logic [31:0] lf;
  int          err_count, compares;
  asr_link_if lnk();
  asr_dev #(.UPDATE_CYC_P(UPD)) i_asr_dev (.ref_clk_i(clk), .nrst_i(nrst), .ext_rst_i(ext_rst),
    .supply_ok_i(sup_ok), .angle_i(ang), .ch1_below_i(c1b), .ch2_below_i(c2b),
    .sample_ready_i(smp), .link(lnk.dev), .tout_o(tout), .trim_mode_o(tm));
  asr_host i_asr_host (.ref_clk_i(clk), .nrst_i(nrst), .read_req_i(rd), .trim_req_i(tr),
    .trim_cmd_i(cmd), .busy_o(busy), .rx_valid_o(rxv), .rx_word_o(rxw), .angle_o(h_ang),
    .status_o(h_st), .err_code_o(h_ec), .parity_err_o(perr), .link(lnk.host));
  asr_link_props i_asr_link_props (.ref_clk_i(clk), .nrst_i(nrst), .sck(lnk.sck),
    .cs_n(lnk.cs_n), .miso(lnk.miso), .trim_clk(lnk.trim_clk), .trim_sel(lnk.trim_sel));
  // ===============
  // Model and tasks
  // ===============
  function automatic logic [15:0] mw(input logic [12:0] a, input logic lost);
    logic [13:0] d;
    d = lost ? {1'b1, a[12:2], 2'b01} : {1'b0, a};
    return {d[13:7], ~^d[13:7], d[6:0], ~^d[6:0]};
  endfunction : mw
  // Pseudo-random source for all random stimulus.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic final_report;
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold
  // Each wait is bounded; running out counts as a mismatch and ends the run.
  task automatic wait_for(input logic want_rx);
    int k;
    for (k = 0; k < 1000 && (want_rx ? rxv !== 1'b1 : busy !== 1'b0); k++) @(negedge clk);
    if (k == 1000) begin
      err_count++;
      final_report();
    end
  endtask : wait_for
  task automatic rd_word(input logic [15:0] e);
    logic [13:0] d;
    d = {e[15:9], e[7:1]};
    rd = 1'b1;
    hold(1);
    rd = 1'b0;
    wait_for(1'b1);
    `CHK("word", e, rxw)
    `CHK("parity", 1'b0, perr)
    `CHK("angle", d[12:0], h_ang)
    `CHK("status", d[13], h_st)
    `CHK("err_code", d[1:0], h_ec)
    hold(1);
  endtask : rd_word
  task automatic trim(input logic [4:0] c, input logic [1:0] e);
    cmd = c;
    tr = 1'b1;
    hold(1);
    tr = 1'b0;
    wait_for(1'b0);
    hold(8);
    m_tm = e;
    if (e == TRIM_NONE) m_tout = 1'b0;
    `CHK("trim", m_tm, tm)
  endtask : trim
  task automatic sample(input logic [14:0] r);
    {c2b, c1b, ang} = r;
    smp = 1'b1;
    hold(1);
    smp = 1'b0;
    if (m_tm != 2'h0 && ang != last_ang) m_tout = ~m_tout;
    last_ang = ang;
    exp_w = mw(ang, c1b & c2b);
    hold(2 * UPD + 4);
  endtask : sample
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // =============
  // Main sequence
  // =============
  initial begin
    {nrst, ext_rst, smp, rd, tr, c1b, c2b, m_tout} = 8'h00;
    {sup_ok, cmd, ang, last_ang, m_tm} = 34'h200000000;
    {err_count, compares, lf} = {32'h0, 32'h0, 32'hFD82};
    hold(8);
    nrst = 1'b1;
    hold(6);
    rd_word(RESET_WORD);
    sample(15'h1FFF);
    rd_word(exp_w);
    sample(15'h6000);
    rd_word(exp_w);
    repeat (6) begin
      lf = lfsr(lf);
      sample(lf[14:0]);
      rd_word(exp_w);
    end
    trim(CMD_TRIM_CH1, TRIM_CH1);
    sample({2'b00, ~last_ang});
    `CHK("tout", m_tout, tout)
    trim(5'h1F, TRIM_CH1);
    trim(CMD_TRIM_CH2, TRIM_CH2);
    trim(CMD_TRIM_EXIT, TRIM_NONE);
    `CHK("tout_off", 1'b0, tout)
    trim(CMD_TRIM_CH2, TRIM_CH2);
    ext_rst = 1'b1;
    {m_tm, m_tout} = 3'h0;
    hold(2);
    ext_rst = 1'b0;
    hold(6);
    `CHK("rst_mode", TRIM_NONE, tm)
    `CHK("rst_tout", 1'b0, tout)
    rd_word(RESET_WORD);
    sample(15'h0123);
    sup_ok = 1'b0;
    hold(2);
    sup_ok = 1'b1;
    hold(6);
    rd_word(RESET_WORD);
    final_report();
  end
endmodule : tb_angle_sensor_serial_output
